// File: hw/acs_clock_rate_select.v
// adc and spdif transmitter clock-source and sample-rate selection with an ahb-lite slave
// Notes on behaviour
// - adc clock select bits 3:2: adc pin, pll a, pll b, main pin; reset 00.
// - with spdif receiver enabled and manual override off, adc clock never uses a pll output.
// - adc rate code comes from routing only; the ratio field drives the separate ratio and divider outputs.
// - primary transmit port carrying adc: rate from primary transmit frame clock.
// - secondary port carrying adc, primary elsewhere: rate from secondary frame clock.
// - spdif transmitter only adc consumer: rate from ratio field bits 7:5.
// - ratio codes 128..1152fs, reset 010, used as rate in spdif-only case and for tx carrying adc without primary.
// - spdif tx clock select bits 5:4, same codes, reset 01.
// - receiver uses pll a; while active and not overridden no pll offered to user paths.
// - tx carrying receiver data forces pll a as tx clock.
// - tx routed from receiver: rate from recovered frame clock.
// - tx routed from primary receive port: rate from primary receive frame clock.
// - tx routed from secondary receive port: rate from secondary receive frame clock.
// - tx carrying adc: primary transmit clock if primary carries adc, else ratio.
// - manual override bit 6, reset 0, disables all automatic clock forcing.
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "acs_clock_rate_regs.vh"
module acs_clock_rate_select
(
	input wire hclk, // bus and logic clock
	input wire hresetn, // asynchronous reset, active low
	input wire hclken, // clock enable, freezes all state when low
	input wire hsel, // slave select
	input wire [31:0] haddr, // byte address
	input wire [1:0] htrans, // transfer type
	input wire hwrite, // write when high
	input wire [2:0] hsize, // transfer size
	input wire [31:0] hwdata, // write data
	input wire hready, // bus ready
	output reg [31:0] hrdata, // read data
	output reg hreadyout, // slave ready
	output reg hresp, // response, always okay
	input wire spdif_rx_enabled, // spdif receiver powered and active
	input wire primary_tx_carries_adc, // primary transmit port sources the adc
	input wire secondary_tx_carries_adc, // secondary transmit port sources the adc
	input wire spdif_tx_carries_adc_only, // spdif tx is the only adc consumer
	input wire [1:0] spdif_tx_source, // spdif tx data source code
	output reg [1:0] adc_clock_source_select, // effective adc clock mux code
	output reg [1:0] spdif_transmit_clock_select, // effective tx clock mux code
	output reg [1:0] adc_rate_source, // adc rate generator reference
	output reg [2:0] adc_oversampling_ratio, // effective ratio code for the adc divider
	output reg [10:0] adc_divide_ratio, // adc clock cycles per sample
	output reg [2:0] spdif_tx_rate_source // tx rate generator reference
);

	reg [8:0] clock_source_select;
	reg [8:0] adc_control_one;
	reg wr_pending;
	reg [7:0] wr_index;
	reg [1:0] next_adc_clk;
	reg [1:0] next_tx_clk;
	reg [1:0] next_adc_rate;
	reg [2:0] next_ratio;
	reg [2:0] next_tx_rate;
	reg [31:0] next_rdata;
	wire [1:0] adc_field;
	wire [1:0] tx_field;
	wire manual;
	wire [2:0] ratio_field;
	wire addr_phase;
	wire [7:0] addr_index;
	wire aligned;
	wire auto_restrict;
	wire [11:0] status_word;

	// a pll code is swapped for the adc pin so the path keeps running off a pin clock
	function [1:0] acs_drop_pll;
		input [1:0] code;
		begin
			if (code == `ACS_CLK_PLL_A || code == `ACS_CLK_PLL_B)
				acs_drop_pll = `ACS_CLK_ADC_PIN;
			else
				acs_drop_pll = code;
		end
	endfunction

	// code 111 has no ratio, so the divider falls back to the reset ratio
	function [2:0] acs_clean_ratio;
		input [2:0] code;
		begin
			if (code == `ACS_RATIO_UNDEF)
				acs_clean_ratio = `ACS_RATIO_RESET;
			else
				acs_clean_ratio = code;
		end
	endfunction

	function [10:0] acs_ratio_cycles;
		input [2:0] code;
		begin
			case (code)
				3'h0: acs_ratio_cycles = 11'h080;
				3'h1: acs_ratio_cycles = 11'h0c0;
				3'h2: acs_ratio_cycles = 11'h100;
				3'h3: acs_ratio_cycles = 11'h180;
				3'h4: acs_ratio_cycles = 11'h200;
				3'h5: acs_ratio_cycles = 11'h300;
				3'h6: acs_ratio_cycles = 11'h480;
				default: acs_ratio_cycles = 11'h100;
			endcase
		end
	endfunction

	// shared by the read mux and the delayed write strobe
	function acs_hits;
		input [7:0] index;
		input [7:0] target;
		begin
			acs_hits = (index == target);
		end
	endfunction

	assign adc_field = clock_source_select[`ACS_ADC_SEL_HI:`ACS_ADC_SEL_LO];
	assign tx_field = clock_source_select[`ACS_TX_SEL_HI:`ACS_TX_SEL_LO];
	assign manual = clock_source_select[`ACS_MANUAL_BIT];
	assign ratio_field = adc_control_one[`ACS_RATIO_HI:`ACS_RATIO_LO];
	assign addr_phase = hsel & hready & (htrans == `ACS_HTRANS_NONSEQ || htrans == `ACS_HTRANS_SEQ);
	assign addr_index = haddr[9:2];
	assign aligned = (haddr[31:10] == 22'h000000) & (haddr[1:0] == 2'h0);
	// pll outputs belong to the receiver while it runs, unless software has taken over
	assign auto_restrict = ~manual & spdif_rx_enabled;
	assign status_word = {spdif_tx_rate_source, adc_oversampling_ratio, adc_rate_source,
		spdif_transmit_clock_select, adc_clock_source_select};

	// adc clock path
	always @*
	begin
		if (auto_restrict)
		begin
			next_adc_clk = acs_drop_pll(adc_field);
		end
		else
		begin
			// manual override leaves the path on its programmed field
			next_adc_clk = adc_field;
		end
	end

	// transmitter clock path
	always @*
	begin
		if (manual)
		begin
			next_tx_clk = tx_field;
		end
		else if (spdif_tx_source == `ACS_TXSRC_SPDIF_RX)
		begin
			next_tx_clk = `ACS_CLK_PLL_A;
		end
		else if (spdif_rx_enabled)
		begin
			next_tx_clk = acs_drop_pll(tx_field);
		end
		else
		begin
			next_tx_clk = tx_field;
		end
	end

	// adc rate reference; primary port wins when several consumers take adc data
	always @*
	begin
		next_ratio = acs_clean_ratio(ratio_field);
		if (primary_tx_carries_adc)
		begin
			next_adc_rate = `ACS_ADCRATE_PRIMARY_TX;
		end
		else if (secondary_tx_carries_adc)
		begin
			next_adc_rate = `ACS_ADCRATE_SECONDARY;
		end
		else if (spdif_tx_carries_adc_only)
		begin
			next_adc_rate = `ACS_ADCRATE_RATIO;
		end
		else
		begin
			next_adc_rate = `ACS_ADCRATE_NONE;
		end
	end

	// transmitter rate reference
	always @*
	begin
		case (spdif_tx_source)
			`ACS_TXSRC_SPDIF_RX:
			begin
				next_tx_rate = `ACS_TXRATE_RECOVERED;
			end
			`ACS_TXSRC_PRIMARY_RX:
			begin
				next_tx_rate = `ACS_TXRATE_PRIMARY_RX;
			end
			`ACS_TXSRC_SECONDARY_RX:
			begin
				next_tx_rate = `ACS_TXRATE_SECONDARY_RX;
			end
			default:
			begin
				if (primary_tx_carries_adc)
					next_tx_rate = `ACS_TXRATE_PRIMARY_TX;
				else
					next_tx_rate = `ACS_TXRATE_RATIO;
			end
		endcase
	end

	// read mux; unmapped or misaligned offsets read as zero
	always @*
	begin
		next_rdata = 32'h00000000;
		if (aligned)
		begin
			if (acs_hits(addr_index, `ACS_IDX_CLOCK_SOURCE_SELECT))
			begin
				next_rdata = {23'h000000, clock_source_select};
			end
			else if (acs_hits(addr_index, `ACS_IDX_ADC_CONTROL_ONE))
			begin
				next_rdata = {23'h000000, adc_control_one};
			end
			else if (acs_hits(addr_index, `ACS_IDX_CLOCK_STATUS))
			begin
				next_rdata = {20'h00000, status_word};
			end
		end
	end

	// bus slave: zero wait states, response always okay
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pending <= 1'b0;
			wr_index <= 8'h00;
		end
		else if (hclken)
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			// write data arrives a cycle after the address, so the index is held over
			wr_pending <= addr_phase & hwrite & aligned;
			wr_index <= addr_index;
			if (addr_phase & ~hwrite)
			begin
				hrdata <= next_rdata;
			end
		end
	end

	// control registers; the status word is read-only and ignores writes
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			clock_source_select <= `ACS_RST_CLOCK_SOURCE_SELECT;
			adc_control_one <= `ACS_RST_ADC_CONTROL_ONE;
		end
		else if (hclken & wr_pending)
		begin
			if (acs_hits(wr_index, `ACS_IDX_CLOCK_SOURCE_SELECT))
			begin
				clock_source_select <= hwdata[8:0];
			end
			if (acs_hits(wr_index, `ACS_IDX_ADC_CONTROL_ONE))
			begin
				adc_control_one <= hwdata[8:0];
			end
		end
	end

	// all clock sources are taken as synchronous to hclk, so no crossing logic sits here
	// selections are registered so every top-level output leaves a flop
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			adc_clock_source_select <= `ACS_CLK_ADC_PIN;
			spdif_transmit_clock_select <= `ACS_CLK_PLL_A;
			adc_rate_source <= `ACS_ADCRATE_NONE;
			adc_oversampling_ratio <= `ACS_RATIO_RESET;
			adc_divide_ratio <= 11'h100;
			spdif_tx_rate_source <= `ACS_TXRATE_RECOVERED;
		end
		else if (hclken)
		begin
			adc_clock_source_select <= next_adc_clk;
			spdif_transmit_clock_select <= next_tx_clk;
			adc_rate_source <= next_adc_rate;
			adc_oversampling_ratio <= next_ratio;
			adc_divide_ratio <= acs_ratio_cycles(next_ratio);
			spdif_tx_rate_source <= next_tx_rate;
		end
	end
endmodule

// File: hw/acs_clock_rate_regs.vh
// register offsets, field positions, reset values and codes of the adc/spdif tx clock select
`ifndef ACS_CLOCK_RATE_REGS_VH
`define ACS_CLOCK_RATE_REGS_VH
`define ACS_IDX_CLOCK_SOURCE_SELECT 8'h08
`define ACS_IDX_ADC_CONTROL_ONE 8'h1d
`define ACS_IDX_CLOCK_STATUS 8'h1e
`define ACS_REG_WIDTH 9
`define ACS_RST_CLOCK_SOURCE_SELECT 9'h010
`define ACS_RST_ADC_CONTROL_ONE 9'h040
`define ACS_ADC_SEL_HI 3
`define ACS_ADC_SEL_LO 2
`define ACS_TX_SEL_HI 5
`define ACS_TX_SEL_LO 4
`define ACS_MANUAL_BIT 6
`define ACS_RATIO_HI 7
`define ACS_RATIO_LO 5
`define ACS_CLK_ADC_PIN 2'h0
`define ACS_CLK_PLL_A 2'h1
`define ACS_CLK_PLL_B 2'h2
`define ACS_CLK_MAIN_PIN 2'h3
`define ACS_RATIO_RESET 3'h2
`define ACS_RATIO_UNDEF 3'h7
`define ACS_TXSRC_SPDIF_RX 2'h0
`define ACS_TXSRC_PRIMARY_RX 2'h1
`define ACS_TXSRC_SECONDARY_RX 2'h2
`define ACS_TXSRC_ADC 2'h3
`define ACS_ADCRATE_PRIMARY_TX 2'h0
`define ACS_ADCRATE_SECONDARY 2'h1
`define ACS_ADCRATE_RATIO 2'h2
`define ACS_ADCRATE_NONE 2'h3
`define ACS_TXRATE_RECOVERED 3'h0
`define ACS_TXRATE_PRIMARY_RX 3'h1
`define ACS_TXRATE_SECONDARY_RX 3'h2
`define ACS_TXRATE_PRIMARY_TX 3'h3
`define ACS_TXRATE_RATIO 3'h4
`define ACS_HTRANS_NONSEQ 2'h2
`define ACS_HTRANS_SEQ 2'h3
`endif

// File: verification/acs_clock_rate_select_chk.sv
// checker of the rate-source and ratio outputs
`timescale 1ns/1ps
`include "acs_clock_rate_regs.vh"
module acs_clock_rate_select_chk
(
	input wire hclk, // clock
	input wire hresetn, // reset, active low
	input wire hclken, // clock enable
	input wire primary_tx_carries_adc, // routing
	input wire secondary_tx_carries_adc, // routing
	input wire spdif_tx_carries_adc_only, // routing
	input wire [1:0] spdif_tx_source, // routing
	input wire [1:0] adc_rate_source, // watched
	input wire [2:0] adc_oversampling_ratio, // watched
	input wire [10:0] adc_divide_ratio, // watched
	input wire [2:0] spdif_tx_rate_source // watched
);
	reg v;
	reg p;
	reg s;
	reg o;
	reg [1:0] t;
	// outputs answer the inputs of the previous edge, so keep a copy of them
	always @(posedge hclk)
	begin
		v <= hresetn && hclken;
		p <= primary_tx_carries_adc;
		s <= secondary_tx_carries_adc;
		o <= spdif_tx_carries_adc_only;
		t <= spdif_tx_source;
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	AST_ADC_PRI:
	assert property (v && p |-> adc_rate_source == `ACS_ADCRATE_PRIMARY_TX) else $error("adc pri");
	AST_ADC_SEC:
	assert property (v && !p && s |-> adc_rate_source == `ACS_ADCRATE_SECONDARY) else $error("adc sec");
	AST_ADC_RAT:
	assert property (v && !p && !s && o |-> adc_rate_source == `ACS_ADCRATE_RATIO) else $error("adc r");
	AST_TX_REC:
	assert property (v && t == 2'h0 |-> spdif_tx_rate_source == 3'h0) else $error("tx recovered");
	AST_TX_PRX:
	assert property (v && t == 2'h1 |-> spdif_tx_rate_source == 3'h1) else $error("tx primary rx");
	AST_TX_SRX:
	assert property (v && t == 2'h2 |-> spdif_tx_rate_source == 3'h2) else $error("tx second rx");
	AST_TX_ADC:
	assert property (v && t == 2'h3 |-> spdif_tx_rate_source == (p ? 3'h3 : 3'h4)) else $error("tx adc");
	AST_NO_UNDEF:
	assert property (adc_oversampling_ratio != `ACS_RATIO_UNDEF) else $error("undefined ratio");
	AST_DIV256:
	assert property (adc_oversampling_ratio == 3'h2 |-> adc_divide_ratio == 11'h100) else $error("div");
endmodule
bind acs_clock_rate_select acs_clock_rate_select_chk u_chk (.hclk(hclk), .hresetn(hresetn),
	.hclken(hclken), .primary_tx_carries_adc(primary_tx_carries_adc),
	.secondary_tx_carries_adc(secondary_tx_carries_adc),
	.spdif_tx_carries_adc_only(spdif_tx_carries_adc_only), .spdif_tx_source(spdif_tx_source),
	.adc_rate_source(adc_rate_source), .adc_oversampling_ratio(adc_oversampling_ratio),
	.adc_divide_ratio(adc_divide_ratio), .spdif_tx_rate_source(spdif_tx_rate_source));

// File: verification/tb_acs_clock_rate_select.sv
// bus-driven testbench of the adc and spdif tx clock and rate selection
`timescale 1ns/1ps
`include "acs_clock_rate_regs.vh"
module tb_acs_clock_rate_select;
	reg hclk = 1'b0;
	reg hresetn = 1'b0;
	reg hsel = 1'b0;
	reg hclken = 1'b1;
	reg hwrite = 1'b0;
	reg [1:0] htrans = 2'h0;
	reg [31:0] haddr = 32'h0;
	reg [31:0] hwdata = 32'h0;
	reg rx = 1'b0, pri = 1'b0, sec = 1'b0, only = 1'b0;
	reg [1:0] src = 2'h2;
	reg [31:0] rd;
	reg [9:0] row;
	wire [31:0] hrdata;
	wire hreadyout, hresp;
	wire [1:0] adc_clk, tx_clk, adc_rs;
	wire [2:0] ratio, tx_rs;
	wire [10:0] div;
	integer errors = 0, total_checks = 0, i, e, m;
	// rows: pri sec only src | adc rate source | tx rate source
	localparam [49:0] TBL = 50'b1000100001_1111100011_0101001010_0011110100_0000011000;
	always #2.5 hclk = ~hclk; // one clock stands for every synchronous source
	acs_clock_rate_select DUT (.hclk(hclk), .hresetn(hresetn), .hclken(hclken), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.spdif_rx_enabled(rx), .primary_tx_carries_adc(pri), .secondary_tx_carries_adc(sec),
		.spdif_tx_carries_adc_only(only), .spdif_tx_source(src),
		.adc_clock_source_select(adc_clk), .spdif_transmit_clock_select(tx_clk),
		.adc_rate_source(adc_rs), .adc_oversampling_ratio(ratio), .adc_divide_ratio(div),
		.spdif_tx_rate_source(tx_rs));
	task close_out;
	begin
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	task chk(input string nm, input [31:0] ex, input [31:0] got);
	begin
		total_checks = total_checks + 1;
		if (got !== ex)
		begin
			errors = errors + 1;
			$display("[ERR] %0s expected %h seen %h", nm, ex, got);
		end
	end
	endtask
	task xfer(input [31:0] a, input w, input [31:0] d);
	begin
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= `ACS_HTRANS_NONSEQ;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	end
	endtask
	task rdchk(input string nm, input [31:0] a, input [31:0] ex);
	begin
		xfer(a, 1'b0, 32'h0);
		chk(nm, ex, rd);
		chk("hresp", 0, hresp);
	end
	endtask
	// outputs follow one edge after a store, so let two edges pass
	task route(input [5:0] r);
	begin
		@(posedge hclk);
		{rx, pri, sec, only, src} <= r;
		repeat (2) @(posedge hclk);
		#1;
	end
	endtask
	initial
	begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		rdchk("clk_sel", 32'h20, 32'h010);
		rdchk("adc_ctl", 32'h74, 32'h040);
		rdchk("unmapped", 32'h40, 32'h0);
		chk("adc_clk", 0, adc_clk);
		chk("tx_clk", 1, tx_clk);
		for (m = 0; m < 2; m = m + 1)
			for (e = 0; e < 2; e = e + 1)
				for (i = 0; i < 4; i = i + 1)
				begin
					xfer(32'h20, 1'b1, m * 64 + i * 20);
					route({e[0], 5'b00010});
					chk("adc_clk", (e && !m && (i[0] ^ i[1])) ? 0 : i, adc_clk);
					chk("tx_clk", (e && !m && (i[0] ^ i[1])) ? 0 : i, tx_clk);
				end
		rdchk("clk_sel", 32'h20, 32'h07c);
		xfer(32'h20, 1'b1, 32'h30);
		route(6'b000000);
		chk("tx_clk", 1, tx_clk);
		xfer(32'h20, 1'b1, 32'h70);
		route(6'b000000);
		chk("tx_clk", 3, tx_clk);
		for (i = 0; i < 5; i = i + 1)
		begin
			row = TBL[i * 10 +: 10];
			route({1'b0, row[9:5]});
			chk("adc_rs", row[4:3], adc_rs);
			chk("tx_rs", row[2:0], tx_rs);
		end
		for (i = 0; i < 8; i = i + 1)
		begin
			xfer(32'h74, 1'b1, i << 5);
			route(6'b000110);
			chk("ratio", (i == 7) ? 2 : i, ratio);
			chk("div", (i == 7) ? 256 : (i == 6) ? 1152 : ((i[0] ? 192 : 128) << i[2:1]), div);
			rdchk("adc_ctl", 32'h74, i << 5);
		end
		// status: tx rate 2, ratio 2, adc rate 2, tx clk 3, adc clk 0
		rdchk("status", 32'h78, 32'h4ac);
		// a low clock enable must freeze the tx rate source output
		@(posedge hclk);
		hclken <= 1'b0;
		route(6'b000000);
		chk("tx_rs_frozen", 2, tx_rs);
		@(posedge hclk);
		hclken <= 1'b1;
		route(6'b000000);
		chk("tx_rs_run", 0, tx_rs);
		// second reset in mid-run brings the registers back to their reset values
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rdchk("clk_sel_rst", 32'h20, 32'h010);
		rdchk("adc_ctl_rst", 32'h74, 32'h040);
		close_out;
	end
	initial
	begin
		#100000;
		errors = errors + 1;
		close_out;
	end
endmodule
